// ===== rtl/dsf_pin_if.sv
// Purpose: Carries synchronised pin levels and their edge pulses to the converter core.
// Assumes: All members are on clk.
// Notes: Edge pulses last one clk cycle.
`timescale 1ns/1ps
interface dsf_pin_if;
	logic csN;
	logic sclk;
	logic dual;
	logic csFall;
	logic csRise;
	logic sclkFall;

	modport sync_side (output csN, output sclk, output dual, output csFall, output csRise,
		output sclkFall);
	modport core_side (input csN, input sclk, input dual, input csFall, input csRise,
		input sclkFall);
endinterface

// ===== rtl/dsf_pin_sync.sv
// Purpose: Brings the host pins into the clk domain and finds their edges.
// Assumes: clk runs several times faster than the serial clock.
// Notes: Edges are taken from the second stage against a third, never from the first.
`timescale 1ns/1ps
module dsf_pin_sync (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Raw pins
	input  wire logic        frameSelectNPin,
	input  wire logic        serialClkPin,
	input  wire logic        twoOutputSelPin,
	// Synchronised view
	dsf_pin_if.sync_side     pins
);

	logic [2:0] csPipe_q;
	logic [2:0] sclkPipe_q;
	logic [1:0] dualPipe_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			csPipe_q   <= 3'h7;
			sclkPipe_q <= 3'h0;
			dualPipe_q <= 2'h3;
		end else begin
			csPipe_q   <= {csPipe_q[1:0], frameSelectNPin};
			sclkPipe_q <= {sclkPipe_q[1:0], serialClkPin};
			dualPipe_q <= {dualPipe_q[0], twoOutputSelPin};
		end
	end

	assign pins.csN      = csPipe_q[1];
	assign pins.sclk     = sclkPipe_q[1];
	assign pins.dual     = dualPipe_q[1];
	assign pins.csFall   = !csPipe_q[1] && csPipe_q[2];
	assign pins.csRise   = csPipe_q[1] && !csPipe_q[2];
	assign pins.sclkFall = !sclkPipe_q[1] && sclkPipe_q[2];

endmodule // dsf_pin_sync

// ===== rtl/dsf_pkg.sv
// Purpose: Shared constants and types for the dual serial frame converter interface.
// Assumes: The serial clock and frame select arrive from a host and are oversampled by clk.
// Notes: Counts below are in serial clock falling edges unless stated otherwise.
package dsf_pkg;

	localparam int unsigned CODE_BITS     = 12;
	localparam int unsigned CODE_STEPS    = 4096;
	localparam logic [11:0] CODE_MAX      = 12'h7FF;
	localparam logic [11:0] CODE_MIN      = 12'h800;
	localparam logic [5:0]  ACQ_EDGES     = 6'h03;
	localparam logic [5:0]  CONV_EDGES    = 6'h0C;
	localparam logic [5:0]  LEAD_ZEROS    = 6'h04;
	localparam logic [5:0]  CONV_START    = 6'h04;
	localparam logic [5:0]  DUAL_PERIOD   = 6'h10;
	localparam logic [5:0]  SINGLE_PERIOD = 6'h20;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WAIT  = 3'b001,
		ST_ACQ   = 3'b010,
		ST_CONV  = 3'b011,
		ST_DRAIN = 3'b100
	} dsf_state_t;

endpackage

// ===== rtl/dsf_top.sv
// Purpose: Frame sequencing and serial result output of a dual simultaneous-sampling converter.
// Assumes: Channel codes arrive already digitised on clk; the host drives frame select and clock.
// Notes: Pins are oversampled, so outputs move two to three clk cycles after each pin edge.
`timescale 1ns/1ps
module dsf_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Host pins
	input  wire logic        frameSelectN,
	input  wire logic        serialClk,
	input  wire logic        twoOutputSel,
	// Digitised channel inputs
	input  wire logic [11:0] diffInputA,
	input  wire logic [11:0] diffInputB,
	// Serial outputs
	output logic             resultOutA,
	output logic             resultOutAOe,
	output logic             resultOutB,
	output logic             resultOutBOe,
	// Status
	output logic             trackMode,
	output logic             convertMode,
	output logic             powerDown,
	output logic             sampleStrobe
);

	dsf_pin_if pins ();

	dsf_pin_sync uSync (
		.clk             (clk),
		.rst_n           (rst_n),
		.frameSelectNPin (frameSelectN),
		.serialClkPin    (serialClk),
		.twoOutputSelPin (twoOutputSel),
		.pins            (pins.sync_side)
	);

	dsf_pkg::dsf_state_t state_q;
	dsf_pkg::dsf_state_t state_d;
	logic [5:0]          edgeCnt_q;
	logic [5:0]          edgeCnt_d;
	logic                dualMode_q;
	logic [11:0]         codeA_q;
	logic [11:0]         codeB_q;
	logic                resultOutA_q;
	logic                resultOutAOe_q;
	logic                resultOutB_q;
	logic                resultOutBOe_q;
	logic                trackMode_q;
	logic                convertMode_q;
	logic                powerDown_q;
	logic                sampleStrobe_q;
	logic                startNow;
	logic                stepEv;
	logic                fallEv;
	logic [5:0]          period;
	logic [5:0]          slot;

	// Returns the bit sent at a given edge of a sixteen-edge slot: zeros first, then MSB down.
	function automatic logic slotBit(input logic [11:0] code, input logic [5:0] pos);
		logic [5:0] idx;
		idx = 6'h00;
		if (pos <= dsf_pkg::LEAD_ZEROS || pos > dsf_pkg::DUAL_PERIOD) begin
			slotBit = 1'b0;
		end else begin
			idx = dsf_pkg::DUAL_PERIOD - pos;
			slotBit = code[idx[3:0]];
		end
	endfunction

	always_comb begin
		startNow  = pins.csFall && !pins.sclk;
		stepEv    = pins.sclkFall && !pins.csN && !pins.csFall && (state_q != dsf_pkg::ST_IDLE);
		fallEv    = startNow || stepEv;
		period    = dualMode_q ? dsf_pkg::DUAL_PERIOD : dsf_pkg::SINGLE_PERIOD;
		edgeCnt_d = edgeCnt_q;
		state_d   = state_q;
		if (pins.csN) begin
			// Rising select ends the frame and abandons any conversion in flight.
			edgeCnt_d = 6'h00;
			state_d   = dsf_pkg::ST_IDLE;
		end else if (pins.csFall && pins.sclk) begin
			edgeCnt_d = 6'h00;
			state_d   = dsf_pkg::ST_WAIT;
		end else if (fallEv) begin
			if (startNow || edgeCnt_q == period) begin
				edgeCnt_d = 6'h01;
			end else begin
				edgeCnt_d = edgeCnt_q + 6'h01;
			end
			if (edgeCnt_d <= dsf_pkg::ACQ_EDGES) begin
				state_d = dsf_pkg::ST_ACQ;
			end else if (edgeCnt_d < dsf_pkg::CONV_START + dsf_pkg::CONV_EDGES + 6'h01) begin
				state_d = dsf_pkg::ST_CONV;
			end else begin
				state_d = dsf_pkg::ST_DRAIN;
			end
		end
		slot = (edgeCnt_d > dsf_pkg::DUAL_PERIOD) ? edgeCnt_d - dsf_pkg::DUAL_PERIOD : edgeCnt_d;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= dsf_pkg::ST_IDLE;
			edgeCnt_q <= 6'h00;
		end else begin
			state_q   <= state_d;
			edgeCnt_q <= edgeCnt_d;
		end
	end

	// The output mode is frozen per frame so a change mid-frame cannot garble a word.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dualMode_q <= 1'b1;
		end else if (pins.csFall) begin
			dualMode_q <= pins.dual;
		end
	end

	// Both channels are taken together on the edge that ends acquisition.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			codeA_q        <= 12'h000;
			codeB_q        <= 12'h000;
			sampleStrobe_q <= 1'b0;
		end else begin
			sampleStrobe_q <= fallEv && (edgeCnt_d == dsf_pkg::CONV_START);
			if (fallEv && edgeCnt_d == dsf_pkg::CONV_START) begin
				codeA_q <= diffInputA;
				codeB_q <= diffInputB;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resultOutAOe_q <= 1'b0;
			resultOutBOe_q <= 1'b0;
		end else if (pins.csN) begin
			resultOutAOe_q <= 1'b0;
			resultOutBOe_q <= 1'b0;
		end else if (pins.csFall) begin
			resultOutAOe_q <= 1'b1;
			resultOutBOe_q <= pins.dual;
		end
	end

	// A falling edge wins over the frame-edge clear; they meet only at a low-clock start.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resultOutA_q <= 1'b0;
			resultOutB_q <= 1'b0;
		end else if (fallEv) begin
			if (dualMode_q || (startNow && pins.dual)) begin
				resultOutA_q <= slotBit(codeA_q, slot);
				resultOutB_q <= slotBit(codeB_q, slot);
			end else begin
				resultOutA_q <= (edgeCnt_d > dsf_pkg::DUAL_PERIOD) ?
					slotBit(codeB_q, slot) : slotBit(codeA_q, slot);
				resultOutB_q <= 1'b0;
			end
		end else if (pins.csN || pins.csFall) begin
			resultOutA_q <= 1'b0;
			resultOutB_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trackMode_q   <= 1'b0;
			convertMode_q <= 1'b0;
			powerDown_q   <= 1'b1;
		end else begin
			trackMode_q   <= (state_d == dsf_pkg::ST_ACQ);
			convertMode_q <= (state_d == dsf_pkg::ST_CONV);
			powerDown_q   <= (state_d == dsf_pkg::ST_IDLE) || (state_d == dsf_pkg::ST_DRAIN);
		end
	end

	assign resultOutA   = resultOutA_q;
	assign resultOutAOe = resultOutAOe_q;
	assign resultOutB   = resultOutB_q;
	assign resultOutBOe = resultOutBOe_q;
	assign trackMode    = trackMode_q;
	assign convertMode  = convertMode_q;
	assign powerDown    = powerDown_q;
	assign sampleStrobe = sampleStrobe_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sLowStart;
		startNow;
	endsequence

	sequence sHighStart;
		pins.csFall && pins.sclk;
	endsequence

	sequence sFourthEdge;
		fallEv && state_q == dsf_pkg::ST_ACQ && edgeCnt_d == dsf_pkg::CONV_START;
	endsequence

	sequence sDualWrap;
		stepEv && dualMode_q && edgeCnt_q == dsf_pkg::DUAL_PERIOD;
	endsequence

	sequence sSingleWrap;
		stepEv && !dualMode_q && edgeCnt_q == dsf_pkg::SINGLE_PERIOD;
	endsequence

	chk_oe_off_high: assert property (
		pins.csN |=> !resultOutAOe_q && !resultOutBOe_q)
		else $error("outputs driven while frame select high");

	chk_oe_on_low: assert property (
		!pins.csN && !pins.csFall |-> resultOutAOe_q)
		else $error("output A not driven inside frame");

	chk_abort_idle: assert property (
		pins.csRise |=> state_q == dsf_pkg::ST_IDLE && powerDown_q && edgeCnt_q == 6'h00)
		else $error("frame end did not abort conversion");

	chk_low_start: assert property (
		sLowStart |=> state_q == dsf_pkg::ST_ACQ && edgeCnt_q == 6'h01 && trackMode_q)
		else $error("low clock start not counted as first edge");

	chk_high_start: assert property (
		sHighStart |=> state_q == dsf_pkg::ST_WAIT && !trackMode_q)
		else $error("high clock start entered acquisition early");

	chk_acq_to_conv: assert property (
		sFourthEdge |=> convertMode_q && sampleStrobe_q ##1 !sampleStrobe_q)
		else $error("conversion not entered on fourth edge");

	chk_code_taken: assert property (
		sFourthEdge |=> codeA_q == $past(diffInputA) && codeB_q == $past(diffInputB))
		else $error("channel codes not captured together");

	chk_lead_zeros: assert property (
		fallEv && slot <= dsf_pkg::LEAD_ZEROS |=> !resultOutA_q && !resultOutB_q)
		else $error("leading bit not zero");

	chk_msb_fifth: assert property (
		fallEv && dualMode_q && edgeCnt_d == 6'h05 |=>
			resultOutA_q == codeA_q[11] && resultOutB_q == codeB_q[11])
		else $error("MSB missing on fifth edge");

	chk_wrap_cont: assert property (
		sDualWrap |=> edgeCnt_q == 6'h01 && state_q == dsf_pkg::ST_ACQ)
		else $error("continuous conversion did not restart");

	chk_single_b_off: assert property (
		!dualMode_q && !pins.csN && !pins.csFall |-> !resultOutBOe_q)
		else $error("B output driven in single mode");

	chk_bit_on_fall: assert property (
		!fallEv && !pins.csN && !pins.csFall |=> $stable(resultOutA_q) && $stable(resultOutB_q))
		else $error("output bit moved without a falling edge");

	chk_oe_b_dual: assert property (
		dualMode_q && !pins.csN && !pins.csFall |-> resultOutBOe_q)
		else $error("output B not driven inside dual frame");

	chk_track_span: assert property (
		fallEv && edgeCnt_d <= dsf_pkg::ACQ_EDGES |=> trackMode_q && !convertMode_q)
		else $error("acquisition flag wrong on edges one to three");

	chk_conv_span: assert property (
		fallEv && edgeCnt_d >= dsf_pkg::CONV_START && edgeCnt_d <= dsf_pkg::DUAL_PERIOD |=>
			convertMode_q && !trackMode_q && !powerDown_q)
		else $error("conversion flag wrong on edges four to sixteen");

	chk_lsb_last: assert property (
		fallEv && dualMode_q && edgeCnt_d == dsf_pkg::DUAL_PERIOD |=>
			resultOutA_q == codeA_q[0] && resultOutB_q == codeB_q[0])
		else $error("LSB missing on sixteenth edge");

	chk_wait_hold: assert property (
		state_q == dsf_pkg::ST_WAIT && !pins.csN && !pins.sclkFall |=>
			state_q == dsf_pkg::ST_WAIT && !trackMode_q)
		else $error("acquisition entered before first falling edge");

	chk_idle_power: assert property (
		pins.csN |=> powerDown_q && !convertMode_q && !trackMode_q)
		else $error("not powered down while frame select high");

	chk_single_wrap: assert property (
		sSingleWrap |=> edgeCnt_q == 6'h01 && state_q == dsf_pkg::ST_ACQ)
		else $error("single output conversion did not restart");

	chk_drain_power: assert property (
		fallEv && edgeCnt_d > dsf_pkg::DUAL_PERIOD |=>
			powerDown_q && !convertMode_q && !trackMode_q)
		else $error("not powered down after sixteenth edge");

	chk_single_b_slot: assert property (
		fallEv && !dualMode_q && edgeCnt_d == 6'h15 |=>
			resultOutA_q == codeB_q[11] && !resultOutB_q)
		else $error("channel B MSB missing in single output slot");

endmodule // dsf_top

// ===== tb/dsf_host_model.sv
// Purpose: Host model that frames conversions and shifts both results in.
// Assumes: Pins move on clk falling edges; one serial clock period is eight clk cycles.
// Notes: The serial clock stands still between frames to save converter power.
`timescale 1ns/1ps
module dsf_host_model (
	// Clock
	input  wire logic clk,
	// Device outputs
	input  wire logic resultOutA,
	input  wire logic resultOutAOe,
	input  wire logic resultOutB,
	input  wire logic resultOutBOe,
	// Host pins
	output logic      frameSelectN,
	output logic      serialClk
);
	initial begin
		frameSelectN = 1'b1;
		serialClk    = 1'b1;
	end

	task automatic half();
		repeat (4) @(negedge clk);
	endtask

	// Start 0: select falls with clock high, 1: with clock low, 2: both fall together.
	task automatic frame(input int start, input int n,
		output logic [63:0] a, output logic [63:0] b,
		output logic [63:0] oa, output logic [63:0] ob);
		a = '0;
		b = '0;
		oa = '0;
		ob = '0;
		serialClk = (start != 1);
		half();
		if (start == 0) begin
			frameSelectN = 1'b0;
			half();
		end
		for (int k = 1; k <= n; k++) begin
			if (k == 1)
				frameSelectN = 1'b0;
			serialClk = 1'b0;
			half();
			// Data moved two and a half clk after the fall, so it is settled at the rise.
			serialClk = 1'b1;
			a = {a[62:0], resultOutA};
			b = {b[62:0], resultOutB};
			oa = {oa[62:0], resultOutAOe};
			ob = {ob[62:0], resultOutBOe};
			half();
		end
		frameSelectN = 1'b1;
		half();
	endtask
endmodule // dsf_host_model

// ===== tb/dsf_top_test.sv
// Purpose: Self-checking bench of the frame sequencer against a host model.
// Assumes: clk at 25 MHz, serial clock at 320 ns, codes held steady through a frame.
// Notes: Edge streams are compared whole, one bit per serial clock falling edge.
`timescale 1ns/1ps
module dsf_top_test;
	logic        clk;
	logic        rst_n;
	logic        twoOutputSel;
	logic [11:0] diffInputA;
	logic [11:0] diffInputB;
	logic        resultOutA;
	logic        resultOutAOe;
	logic        resultOutB;
	logic        resultOutBOe;
	logic        trackMode;
	logic        convertMode;
	logic        powerDown;
	logic        sampleStrobe;
	logic        frameSelectN;
	logic        serialClk;
	logic [63:0] capA;
	logic [63:0] capB;
	logic [63:0] capOeA;
	logic [63:0] capOeB;
	logic [63:0] modeCap;
	logic [63:0] convCap;
	logic [63:0] pdCap;
	int          strobeCnt = 0;
	int          fail_count = 0;
	int          n_tests = 0;

	dsf_top u_dut (.clk(clk), .rst_n(rst_n), .frameSelectN(frameSelectN),
		.serialClk(serialClk), .twoOutputSel(twoOutputSel), .diffInputA(diffInputA),
		.diffInputB(diffInputB), .resultOutA(resultOutA), .resultOutAOe(resultOutAOe),
		.resultOutB(resultOutB), .resultOutBOe(resultOutBOe), .trackMode(trackMode),
		.convertMode(convertMode), .powerDown(powerDown), .sampleStrobe(sampleStrobe));

	dsf_host_model u_host (.clk(clk), .resultOutA(resultOutA), .resultOutAOe(resultOutAOe),
		.resultOutB(resultOutB), .resultOutBOe(resultOutBOe),
		.frameSelectN(frameSelectN), .serialClk(serialClk));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge serialClk)
		if (!frameSelectN) begin
			modeCap <= {modeCap[62:0], trackMode};
			convCap <= {convCap[62:0], convertMode};
			pdCap   <= {pdCap[62:0], powerDown};
		end

	// Sampled on the falling clk edge, opposite the rising launch edge, so the one-cycle pulse is seen settled.
	always @(negedge clk)
		if (sampleStrobe)
			strobeCnt++;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Codes are taken once per conversion, at its fourth edge.
	function automatic int expStrobes(input int per, input int n);
		return (n > 3) ? (n - 4) / per + 1 : 0;
	endfunction

	// Bit per edge: zeros then code MSB first; sel 1 to 3 give track, convert, power-down.
	function automatic logic [63:0] expStream(input logic [11:0] a, input logic [11:0] b,
		input int per, input int n, input int sel);
		logic [63:0] s;
		int          p;
		s = '0;
		for (int k = 0; k < n; k++) begin
			p = k % per;
			if (sel == 1)
				s = {s[62:0], 1'(p < 3)};
			else if (sel == 2)
				s = {s[62:0], 1'(p >= 3 && p < 16)};
			else if (sel == 3)
				s = {s[62:0], 1'(p >= 16)};
			else if (p % 16 < 4)
				s = {s[62:0], 1'b0};
			else
				s = {s[62:0], (p < 16) ? a[15 - p % 16] : b[15 - p % 16]};
		end
		return s;
	endfunction

	task automatic run(input int start, input bit dual, input int n,
		input logic [11:0] a, input logic [11:0] b);
		@(negedge clk);
		twoOutputSel = dual;
		diffInputA = a;
		diffInputB = b;
		modeCap = '0;
		convCap = '0;
		pdCap = '0;
		strobeCnt = 0;
		u_host.frame(start, n, capA, capB, capOeA, capOeB);
		check(capA, expStream(a, dual ? a : b, dual ? 16 : 32, n, 0));
		check(capB, dual ? expStream(b, b, 16, n, 0) : 64'h0);
		check(modeCap, expStream(a, b, dual ? 16 : 32, n, 1));
		check(convCap, expStream(a, b, dual ? 16 : 32, n, 2));
		check(pdCap, expStream(a, b, dual ? 16 : 32, n, 3));
		check(64'(strobeCnt), 64'(expStrobes(dual ? 16 : 32, n)));
		check(capOeA, (64'h1 << n) - 1);
		check(capOeB, dual ? (64'h1 << n) - 1 : 64'h0);
		check({61'h0, resultOutAOe, resultOutBOe, powerDown}, 64'h1);
		$display("frame start=%0d dual=%0d edges=%0d done", start, dual, n);
	endtask

	initial begin
		rst_n = 1'b0;
		twoOutputSel = 1'b1;
		diffInputA = '0;
		diffInputB = '0;
		void'($urandom(32'h3E98FE44));
		repeat (3) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (4) @(negedge clk);
		run(0, 1, 16, 12'h7FF, 12'h800);
		run(1, 1, 16, 12'h800, 12'h7FF);
		run(2, 1, 48, 12'hA5C, 12'h3C1);
		run(0, 0, 32, 12'h123, 12'hFED);
		run(1, 0, 64, 12'h801, 12'h7FE);
		run(0, 1, 7, 12'hF0F, 12'h0F0);
		run(2, 1, 16, 12'h0F0, 12'hF0F);
		for (int i = 0; i < 10; i++)
			run(int'($urandom_range(2)), 1'($urandom_range(1)), int'($urandom_range(64, 1)),
				12'($urandom), 12'($urandom));
		conclude();
	end

	initial begin
		#2000000;
		fail_count++;
		conclude();
	end
endmodule // dsf_top_test
